// File: vicfg_regs.sv
// input configuration register bank of the convolutional decoder
// What this block does
// (RL1) four generator bytes, three high, zero low
// (RL2) nine-bit polynomials, constant coefficient forced one
// (RL3) first-delay tap in byte msb
// (RL4) bit 28 enables early decision
// (RL5) twelve-bit early decision threshold, bits 27-16
// (RL6) reserved bits read zero, ignore writes
// (RL7) host writes zero to low reserved bits
// (RL8) reliability length in bits 31-16
// (RL9) frame length in bits 15-0
// (RL10) bit 28 picks output bit order
// (RL11) bit 24 enables programmed traceback start
// (RL12) bits 23-16 give traceback start state
// (RL13) convergence distance, used only when frame long
// (RL14) thirteen-bit low metric, bits 28-16
// (RL15) thirteen-bit peak metric, bits 12-0
// (RL16) selected state peak metric, others low
// (RL17) host keeps configuration stable during decode
`timescale 1ns/1ps
`include "vicfg_map.svh"

module vicfg_regs (
    input  wire logic        sys_clk,                      // system clock, 25 MHz
    input  wire logic        rstn,                         // async reset, active low
    // memory-mapped register port
    input  wire logic [15:0] bus_addr,                     // byte address
    input  wire logic        bus_wr,                       // write strobe
    input  wire logic        bus_rd,                       // read strobe
    input  wire logic [31:0] bus_wdata,                    // write data
    output logic      [31:0] bus_rdata,                    // read data
    output logic             bus_rvalid,                   // read answer strobe
    // generator polynomials, coefficient k at bit k
    output logic      [8:0]  generator_taps_zero,          // polynomial g0
    output logic      [8:0]  generator_taps_one,           // polynomial g1
    output logic      [8:0]  generator_taps_two,           // polynomial g2
    output logic      [8:0]  generator_taps_three,         // polynomial g3
    // early decision
    output logic             yamamoto_enable,              // early decision on
    output logic      [11:0] yamamoto_threshold,           // early decision threshold
    // lengths
    output logic      [15:0] reliability_length,           // sliding window length
    output logic      [15:0] frame_length,                 // frame length
    // traceback and output order
    output logic             traceback_start_load_enable,  // start from programmed state
    output logic      [7:0]  traceback_start_index,        // programmed start state
    output logic      [15:0] convergence_distance,         // convergent section length
    input  wire logic [1:0]  traceback_mode,               // mode from the datapath
    input  wire logic [3:0]  constraint_length,            // code constraint length
    output logic             convergence_distance_used,    // distance applies
    input  wire logic [31:0] decision_word_in,             // decisions, bit 0 first
    output logic      [31:0] decision_word_out,            // decisions in chosen order
    // initial state metrics
    output logic      [12:0] low_initial_metric,           // metric of other states
    output logic      [12:0] peak_initial_metric,          // metric of selected state
    output logic      [7:0]  peak_metric_state_select,     // selected state
    input  wire logic [7:0]  metric_query_idx,             // state being initialised
    output logic      [12:0] metric_query_value            // its metric, one cycle later
);

    logic rst_meta_ff;  // reset release, first stage
    logic rst_sync_ff;  // reset release, second stage

    vicfg_pkg::vicfg_state_s st_ff;   // registered state
    vicfg_pkg::vicfg_state_s nxt_st;  // next state

    logic        hit_gen;   // address decodes
    logic        hit_edc;
    logic        hit_flen;
    logic        hit_tbo;
    logic        hit_ism;
    logic        hit_sel;
    logic [16:0] conv_lim;  // frame limit for convergent mode
    logic [16:0] mix_lim;   // frame limit for mixed mode

    // reset is released synchronously so no flop sees a runt edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // turn a stored tap byte into a 9-bit polynomial
    function automatic logic [8:0] expand_poly(input logic [7:0] taps);
        logic [8:0] p;
        p = 9'h001; // RL2
        for (int k = 1; k <= 8; k++) begin
            p[k] = taps[8 - k]; // RL3
        end
        return p;
    endfunction

    // reverse bit order of a decision word
    function automatic logic [31:0] flip_word(input logic [31:0] w);
        logic [31:0] r;
        r = 32'h00000000;
        for (int k = 0; k < 32; k++) begin
            r[k] = w[31 - k];
        end
        return r;
    endfunction

    // address decode, full match on aligned words
    always_comb begin
        hit_gen  = (bus_addr == `VICFG_OFS_GEN);
        hit_edc  = (bus_addr == `VICFG_OFS_EDC);
        hit_flen = (bus_addr == `VICFG_OFS_FLEN);
        hit_tbo  = (bus_addr == `VICFG_OFS_TBO);
        hit_ism  = (bus_addr == `VICFG_OFS_ISM);
        hit_sel  = (bus_addr == `VICFG_OFS_SEL);
    end

    // frame length thresholds, one bit wider so no sum wraps
    always_comb begin
        conv_lim = {1'b0, st_ff.flen_ff[`VICFG_HI_MSB:`VICFG_HI_LSB]}
                 + {1'b0, st_ff.tbo_ff[`VICFG_LO_MSB:`VICFG_LO_LSB]};
        mix_lim  = {1'b0, st_ff.flen_ff[`VICFG_HI_MSB:`VICFG_HI_LSB]}
                 + {13'h0000, constraint_length} - 17'h00001;
    end

    // next state: register writes, read answer and derived outputs
    always_comb begin
        nxt_st = st_ff;
        // writes keep only the defined bits, reserved bits stay zero
        if (bus_wr) begin
            if (hit_gen) begin
                nxt_st.gen_ff = bus_wdata & `VICFG_MASK_GEN; // RL1
            end
            if (hit_edc) begin
                // low half is masked, whatever the host puts there
                nxt_st.edc_ff = bus_wdata & `VICFG_MASK_EDC; // RL6
            end
            if (hit_flen) begin
                nxt_st.flen_ff = bus_wdata & `VICFG_MASK_FLEN; // RL8 RL9
            end
            if (hit_tbo) begin
                nxt_st.tbo_ff = bus_wdata & `VICFG_MASK_TBO; // RL6
            end
            if (hit_ism) begin
                nxt_st.ism_ff = bus_wdata & `VICFG_MASK_ISM; // RL14 RL15
            end
            if (hit_sel) begin
                nxt_st.sel_ff = bus_wdata[7:0]; // RL16
            end
        end
        // reads answer one cycle later; unmapped reads give zero
        nxt_st.rvalid_ff = bus_rd;
        if (bus_rd) begin
            if (hit_gen) begin
                nxt_st.rdata_ff = st_ff.gen_ff;
            end else if (hit_edc) begin
                nxt_st.rdata_ff = st_ff.edc_ff;
            end else if (hit_flen) begin
                nxt_st.rdata_ff = st_ff.flen_ff;
            end else if (hit_tbo) begin
                nxt_st.rdata_ff = st_ff.tbo_ff;
            end else if (hit_ism) begin
                nxt_st.rdata_ff = st_ff.ism_ff;
            end else if (hit_sel) begin
                nxt_st.rdata_ff = {24'h000000, st_ff.sel_ff};
            end else begin
                nxt_st.rdata_ff = 32'h00000000; // RL6
            end
        end else begin
            // data is only meaningful with the strobe; hold zero between
            nxt_st.rdata_ff = 32'h00000000;
        end
        // decision word order
        if (st_ff.tbo_ff[`VICFG_ORDER_BIT]) begin
            nxt_st.dec_ff = flip_word(decision_word_in); // RL10
        end else begin
            nxt_st.dec_ff = decision_word_in; // RL10
        end
        // the distance only matters when the frame outruns the window
        unique case (traceback_mode)
            `VICFG_TB_MIXED: begin
                nxt_st.conv_ff = {1'b0, st_ff.flen_ff[`VICFG_LO_MSB:`VICFG_LO_LSB]}
                               > mix_lim; // RL13
            end
            `VICFG_TB_CONV: begin
                nxt_st.conv_ff = {1'b0, st_ff.flen_ff[`VICFG_LO_MSB:`VICFG_LO_LSB]}
                               > conv_lim; // RL13
            end
            default: begin
                // tailed mode and the illegal code never use it
                nxt_st.conv_ff = 1'b0;
            end
        endcase
    end

    // state register, cleared by the synchronised reset
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            st_ff.gen_ff    <= `VICFG_RST_WORD;
            st_ff.edc_ff    <= `VICFG_RST_WORD;
            st_ff.flen_ff   <= `VICFG_RST_WORD;
            st_ff.tbo_ff    <= `VICFG_RST_WORD;
            st_ff.ism_ff    <= `VICFG_RST_WORD;
            st_ff.sel_ff    <= `VICFG_RST_SEL;
            st_ff.rdata_ff  <= 32'h00000000;
            st_ff.rvalid_ff <= 1'b0;
            st_ff.dec_ff    <= 32'h00000000;
            st_ff.conv_ff   <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // bus answer
    assign bus_rdata  = st_ff.rdata_ff;
    assign bus_rvalid = st_ff.rvalid_ff;

    // generator fields, three in top byte down to zero in bottom byte
    assign generator_taps_zero  = expand_poly(st_ff.gen_ff[7:0]);   // RL1
    assign generator_taps_one   = expand_poly(st_ff.gen_ff[15:8]);  // RL1
    assign generator_taps_two   = expand_poly(st_ff.gen_ff[23:16]); // RL1
    assign generator_taps_three = expand_poly(st_ff.gen_ff[31:24]); // RL1

    // early decision fields
    assign yamamoto_enable    = st_ff.edc_ff[`VICFG_YAM_EN_BIT]; // RL4
    assign yamamoto_threshold = st_ff.edc_ff[`VICFG_YAM_T_MSB:`VICFG_YAM_T_LSB]; // RL5

    // length fields
    assign reliability_length = st_ff.flen_ff[`VICFG_HI_MSB:`VICFG_HI_LSB]; // RL8
    assign frame_length       = st_ff.flen_ff[`VICFG_LO_MSB:`VICFG_LO_LSB]; // RL9

    // traceback fields
    assign traceback_start_load_enable = st_ff.tbo_ff[`VICFG_TB_EN_BIT]; // RL11
    assign traceback_start_index = st_ff.tbo_ff[`VICFG_TB_IDX_MSB:`VICFG_TB_IDX_LSB]; // RL12
    assign convergence_distance  = st_ff.tbo_ff[`VICFG_LO_MSB:`VICFG_LO_LSB]; // RL13
    assign convergence_distance_used = st_ff.conv_ff;
    assign decision_word_out     = st_ff.dec_ff;

    // metric fields
    assign low_initial_metric  = st_ff.ism_ff[`VICFG_LOWM_MSB:`VICFG_LOWM_LSB]; // RL14
    assign peak_initial_metric = st_ff.ism_ff[`VICFG_PEAKM_MSB:`VICFG_PEAKM_LSB]; // RL15
    assign peak_metric_state_select = st_ff.sel_ff;

    // per-state initial metric; registered so the datapath sees a clean value
    vicfg_metric_init u_metric_init (
        .clk          (sys_clk),
        .rst_n        (rst_sync_ff),
        .query_idx    (metric_query_idx),
        .peak_select  (st_ff.sel_ff),
        .peak_metric  (peak_initial_metric),
        .low_metric   (low_initial_metric),
        .metric_value (metric_query_value)
    );

    // checks on the register behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_ff);

    // write, one idle cycle, then read back
    a_gen_readback: assert property ( // RL1
        bus_wr && hit_gen ##1 !(bus_wr && hit_gen)
            ##1 bus_rd && hit_gen && !bus_wr
            |=> bus_rdata == $past(bus_wdata, 3))
        else $error("generator word did not read back");

    a_poly_const_tap: assert property ( // RL2
        generator_taps_zero[0] && generator_taps_one[0]
            && generator_taps_two[0] && generator_taps_three[0])
        else $error("constant polynomial coefficient not forced");

    a_poly_tap_order: assert property ( // RL3
        bus_wr && hit_gen |=> generator_taps_zero[1] == $past(bus_wdata[7])
            && generator_taps_zero[8] == $past(bus_wdata[0]))
        else $error("polynomial tap order wrong");

    a_yam_enable_set: assert property ( // RL4
        bus_wr && hit_edc |=> yamamoto_enable == $past(bus_wdata[28]))
        else $error("early decision enable not taken from bit 28");

    a_yam_threshold: assert property ( // RL5
        bus_wr && hit_edc |=> yamamoto_threshold == $past(bus_wdata[27:16]))
        else $error("early decision threshold wrong");

    // mask chosen by the address of the previous cycle
    a_reserved_zero: assert property ( // RL6
        bus_rvalid |-> (bus_rdata & ~($past(hit_edc) ? `VICFG_MASK_EDC
            : $past(hit_tbo) ? `VICFG_MASK_TBO
            : $past(hit_ism) ? `VICFG_MASK_ISM
            : $past(hit_sel) ? `VICFG_MASK_SEL
            : ($past(hit_gen) || $past(hit_flen)) ? 32'hFFFFFFFF : 32'h00000000)) == 32'h0)
        else $error("reserved bits read non-zero");

    a_length_split: assert property ( // RL8
        bus_wr && hit_flen |=> reliability_length == $past(bus_wdata[31:16])
            && frame_length == $past(bus_wdata[15:0]))
        else $error("length fields wrong");

    a_order_reverse: assert property ( // RL10
        st_ff.tbo_ff[`VICFG_ORDER_BIT]
            |=> decision_word_out[0] == $past(decision_word_in[31])
            && decision_word_out[31] == $past(decision_word_in[0]))
        else $error("reversed order not applied");

    a_order_straight: assert property ( // RL10
        !st_ff.tbo_ff[`VICFG_ORDER_BIT]
            |=> decision_word_out == $past(decision_word_in))
        else $error("straight order not kept");

    a_tb_start: assert property ( // RL11
        bus_wr && hit_tbo |=> traceback_start_load_enable == $past(bus_wdata[24])
            && traceback_start_index == $past(bus_wdata[23:16]))
        else $error("traceback start fields wrong");

    // tailed and illegal modes never use the distance
    a_conv_tailed: assert property ( // RL13
        traceback_mode != `VICFG_TB_CONV && traceback_mode != `VICFG_TB_MIXED
            |=> !convergence_distance_used)
        else $error("distance flagged in tailed mode");

    a_metric_fields: assert property ( // RL14
        bus_wr && hit_ism |=> low_initial_metric == $past(bus_wdata[28:16])
            && peak_initial_metric == $past(bus_wdata[12:0]))
        else $error("initial metric fields wrong");

    a_read_strobe: assert property (
        bus_rvalid == $past(bus_rd))
        else $error("read strobe timing wrong");

    // between answers the data lines rest at zero
    a_idle_data: assert property (
        !bus_rvalid |-> bus_rdata == 32'h00000000)
        else $error("read data not zero while idle");

    c_gen_write: cover property (bus_wr && hit_gen);
    c_unmapped_read: cover property (bus_rd && !hit_gen && !hit_edc && !hit_flen
        && !hit_tbo && !hit_ism && !hit_sel);
    c_mixed_used: cover property (traceback_mode == `VICFG_TB_MIXED
        && convergence_distance_used);
    c_reverse_order: cover property (st_ff.tbo_ff[28] && decision_word_in != 32'h0);
    c_conv_used: cover property (convergence_distance_used);

endmodule

// File: vicfg_map.svh
// register offsets, field positions and reset values of the input configuration bank
`ifndef VICFG_MAP_SVH
`define VICFG_MAP_SVH

// byte offsets on the memory-mapped bus
`define VICFG_OFS_GEN      16'h0000
`define VICFG_OFS_EDC      16'h0004
`define VICFG_OFS_FLEN     16'h0008
`define VICFG_OFS_TBO      16'h000C
`define VICFG_OFS_ISM      16'h0010
`define VICFG_OFS_SEL      16'h0014

// writable bit masks; everything else is reserved
`define VICFG_MASK_GEN     32'hFFFFFFFF
`define VICFG_MASK_EDC     32'h1FFF0000
`define VICFG_MASK_FLEN    32'hFFFFFFFF
`define VICFG_MASK_TBO     32'h11FFFFFF
`define VICFG_MASK_ISM     32'h1FFF1FFF
`define VICFG_MASK_SEL     32'h000000FF

// reset values
`define VICFG_RST_WORD     32'h00000000
`define VICFG_RST_SEL      8'h00

// field positions
`define VICFG_YAM_EN_BIT   28
`define VICFG_YAM_T_MSB    27
`define VICFG_YAM_T_LSB    16
`define VICFG_ORDER_BIT    28
`define VICFG_TB_EN_BIT    24
`define VICFG_TB_IDX_MSB   23
`define VICFG_TB_IDX_LSB   16
`define VICFG_HI_MSB       31
`define VICFG_HI_LSB       16
`define VICFG_LO_MSB       15
`define VICFG_LO_LSB       0
`define VICFG_LOWM_MSB     28
`define VICFG_LOWM_LSB     16
`define VICFG_PEAKM_MSB    12
`define VICFG_PEAKM_LSB    0

// traceback mode codes seen on the mode input
`define VICFG_TB_CONV      2'h2
`define VICFG_TB_MIXED     2'h3

`endif

// File: vicfg_pkg.sv
// types shared by the input configuration bank and its metric initialiser
package vicfg_pkg;

    // whole state of the register bank
    typedef struct packed {
        logic [31:0] gen_ff;      // generator polynomial word
        logic [31:0] edc_ff;      // early decision word
        logic [31:0] flen_ff;     // reliability and frame length word
        logic [31:0] tbo_ff;      // traceback and order word
        logic [31:0] ism_ff;      // initial metric word
        logic [7:0]  sel_ff;      // peak metric state select
        logic [31:0] rdata_ff;    // read data
        logic        rvalid_ff;   // read answer strobe
        logic [31:0] dec_ff;      // reordered decision word
        logic        conv_ff;     // convergence distance in use
    } vicfg_state_s;

    // state of the metric initialiser
    typedef struct packed {
        logic [12:0] metric_ff;   // metric for the queried state
    } vicfg_metric_s;

endpackage

// File: vicfg_metric_init.sv
// initial state metric chooser for one queried state
`timescale 1ns/1ps
`include "vicfg_map.svh"

module vicfg_metric_init (
    input  wire logic        clk,          // system clock
    input  wire logic        rst_n,        // synchronised reset, active low
    input  wire logic [7:0]  query_idx,    // state being initialised
    input  wire logic [7:0]  peak_select,  // state that gets the peak metric
    input  wire logic [12:0] peak_metric,  // peak initial metric
    input  wire logic [12:0] low_metric,   // metric of every other state
    output logic      [12:0] metric_value  // registered metric, one cycle later
);

    vicfg_pkg::vicfg_metric_s st_ff;   // registered state
    vicfg_pkg::vicfg_metric_s nxt_st;  // next state

    // only the selected state starts high, all others low
    always_comb begin
        nxt_st = st_ff;
        if (query_idx == peak_select) begin
            nxt_st.metric_ff = peak_metric; // RL16
        end else begin
            nxt_st.metric_ff = low_metric; // RL16
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign metric_value = st_ff.metric_ff;

    a_peak_state_pick: assert property (@(posedge clk) disable iff (!rst_n) // RL16
        query_idx == peak_select |=> metric_value == $past(peak_metric))
        else $error("selected state did not get the peak metric");

    a_low_state_pick: assert property (@(posedge clk) disable iff (!rst_n) // RL16
        query_idx != peak_select |=> metric_value == $past(low_metric))
        else $error("other state did not get the low metric");

endmodule

// File: vicfg_host_model.sv
// host side bus master issuing single word accesses to the bank
`timescale 1ns/1ps

module vicfg_host_model (
    input  wire logic        sys_clk,    // system clock
    output logic      [15:0] bus_addr,   // byte address
    output logic             bus_wr,     // write strobe
    output logic             bus_rd,     // read strobe
    output logic      [31:0] bus_wdata,  // write data
    input  wire logic [31:0] bus_rdata,  // read data
    input  wire logic        bus_rvalid  // read answer strobe
);
    // idle bus at time zero
    initial begin
        bus_addr = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 32'h00000000;
    end

    // one word write; callers may set reserved bits, the bank masks them
    task automatic write_word(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        // released lines toggle so a stale value is never relied on
        bus_addr <= ~a;
        bus_wdata <= ~d;
        #1;
    endtask

    // one word read, answer taken one cycle after the strobe edge
    task automatic read_word(input logic [15:0] a, output logic [31:0] d, output logic v);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        #1;
        d = bus_rdata;
        v = bus_rvalid;
    endtask
endmodule

// File: testbench.sv
// self-checking bench of the input configuration register bank
`timescale 1ns/1ps
`include "vicfg_map.svh"

`define TB_CHK(what, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
end

module testbench;
    logic        sys_clk;       // 25 MHz clock
    logic        rstn;          // reset, active low
    logic [15:0] bus_addr;      // host address
    logic        bus_wr;        // host write strobe
    logic        bus_rd;        // host read strobe
    logic [31:0] bus_wdata;     // host write data
    logic [31:0] bus_rdata;     // read data
    logic        bus_rvalid;    // read answer
    logic [8:0]  taps [4];      // decoded polynomials
    logic        yam_en;        // early decision on
    logic [11:0] yam_thr;       // early decision threshold
    logic [15:0] rel_len;       // reliability length
    logic [15:0] frm_len;       // frame length
    logic        tb_en;         // programmed traceback start
    logic [7:0]  tb_idx;        // traceback start state
    logic [15:0] conv_dist;     // convergence distance
    logic [1:0]  tb_mode;       // traceback mode stimulus
    logic [3:0]  k_len;         // constraint length stimulus
    logic        conv_used;     // distance applies
    logic [31:0] dec_in;        // decision word stimulus
    logic [31:0] dec_out;       // reordered decisions
    logic [12:0] low_m;         // low initial metric
    logic [12:0] peak_m;        // peak initial metric
    logic [7:0]  peak_sel;      // peak metric state
    logic [7:0]  q_idx;         // queried state
    logic [12:0] q_val;         // queried metric
    int          fails;         // mismatches seen
    int          total_checks;  // comparisons made

    // free running clock, 40 ns period
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    vicfg_host_model i_host (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid));

    vicfg_regs i_dut (.sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rvalid(bus_rvalid), .generator_taps_zero(taps[0]),
        .generator_taps_one(taps[1]), .generator_taps_two(taps[2]),
        .generator_taps_three(taps[3]), .yamamoto_enable(yam_en),
        .yamamoto_threshold(yam_thr), .reliability_length(rel_len),
        .frame_length(frm_len), .traceback_start_load_enable(tb_en),
        .traceback_start_index(tb_idx), .convergence_distance(conv_dist),
        .traceback_mode(tb_mode), .constraint_length(k_len),
        .convergence_distance_used(conv_used), .decision_word_in(dec_in),
        .decision_word_out(dec_out), .low_initial_metric(low_m),
        .peak_initial_metric(peak_m), .peak_metric_state_select(peak_sel),
        .metric_query_idx(q_idx), .metric_query_value(q_val));

    // expected polynomial: byte msb is the first delay tap, constant tap forced
    function automatic logic [8:0] taps_of(input logic [7:0] b);
        taps_of = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7], 1'b1};
    endfunction

    // read one word and compare answer strobe and data
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        i_host.read_word(a, d, v);
        `TB_CHK("rvalid", 1'b1, v)
        `TB_CHK("rdata", exp, d)
    endtask

    // present streaming inputs for one edge, then let the result settle
    task automatic stream(input logic [1:0] m, input logic [3:0] k, input logic [31:0] w,
                          input logic [7:0] q);
        @(posedge sys_clk);
        tb_mode <= m;
        k_len <= k;
        dec_in <= w;
        q_idx <= q;
        @(posedge sys_clk);
        #1;
    endtask

    // single exit point of the run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        $display("mismatch watchdog expected done seen hang");
        report_and_stop();
    end

    // main sequence
    initial begin
        fails = 0;
        total_checks = 0;
        rstn = 1'b0;
        tb_mode = 2'h1;
        k_len = 4'h5;
        dec_in = 32'h00000000;
        q_idx = 8'h00;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        // two sync flops: first access at the third edge
        repeat (3) @(posedge sys_clk);
        #1;
        `TB_CHK("taps0 rst", 9'h001, taps[0])
        `TB_CHK("yam_en rst", 1'b0, yam_en)
        for (int i = 0; i < 6; i++) rd_chk(16'(i * 4), 32'h00000000);
        // one byte pattern per generator, first delay in the byte msb
        i_host.write_word(`VICFG_OFS_GEN, 32'h8001C35A);
        `TB_CHK("taps0", taps_of(8'h5A), taps[0])
        `TB_CHK("taps1", taps_of(8'hC3), taps[1])
        `TB_CHK("taps2", taps_of(8'h01), taps[2])
        `TB_CHK("taps3", taps_of(8'h80), taps[3])
        rd_chk(`VICFG_OFS_GEN, 32'h8001C35A);
        i_host.write_word(`VICFG_OFS_EDC, 32'hFFFF0000);
        rd_chk(`VICFG_OFS_EDC, 32'h1FFF0000);
        `TB_CHK("yam_en", 1'b1, yam_en)
        `TB_CHK("yam_thr", 12'hFFF, yam_thr)
        i_host.write_word(`VICFG_OFS_EDC, 32'h0ABC0000);
        `TB_CHK("yam_en off", 1'b0, yam_en)
        `TB_CHK("yam_thr", 12'hABC, yam_thr)
        i_host.write_word(`VICFG_OFS_FLEN, 32'h00100015);
        rd_chk(`VICFG_OFS_FLEN, 32'h00100015);
        `TB_CHK("rel_len", 16'h0010, rel_len)
        `TB_CHK("frm_len", 16'h0015, frm_len)
        i_host.write_word(`VICFG_OFS_TBO, 32'hFFFFFFFF);
        rd_chk(`VICFG_OFS_TBO, 32'h11FFFFFF);
        `TB_CHK("tb_en", 1'b1, tb_en)
        `TB_CHK("tb_idx", 8'hFF, tb_idx)
        `TB_CHK("conv_dist", 16'hFFFF, conv_dist)
        stream(2'h1, 4'h5, 32'h0000000B, 8'h00);
        `TB_CHK("dec reversed", 32'hD0000000, dec_out)
        // configuration settled before the datapath is exercised
        i_host.write_word(`VICFG_OFS_TBO, 32'h00560003);
        `TB_CHK("tb_en off", 1'b0, tb_en)
        `TB_CHK("tb_idx", 8'h56, tb_idx)
        stream(2'h1, 4'h5, 32'h0000000B, 8'h00);
        `TB_CHK("dec straight", 32'h0000000B, dec_out)
        `TB_CHK("conv tailed", 1'b0, conv_used)
        stream(2'h2, 4'h5, 32'h0, 8'h00);
        `TB_CHK("conv conv", 1'b1, conv_used)
        stream(2'h0, 4'h5, 32'h0, 8'h00);
        `TB_CHK("conv illegal", 1'b0, conv_used)
        stream(2'h3, 4'h5, 32'h0, 8'h00);
        `TB_CHK("conv mix", 1'b1, conv_used)
        stream(2'h3, 4'h6, 32'h0, 8'h00);
        `TB_CHK("conv mix edge", 1'b0, conv_used)
        i_host.write_word(`VICFG_OFS_FLEN, 32'h00100013);
        stream(2'h2, 4'h5, 32'h0, 8'h00);
        `TB_CHK("conv edge", 1'b0, conv_used)
        i_host.write_word(`VICFG_OFS_ISM, 32'hFFFFFFFF);
        rd_chk(`VICFG_OFS_ISM, 32'h1FFF1FFF);
        i_host.write_word(`VICFG_OFS_ISM, 32'h0AAA1555);
        `TB_CHK("low_m", 13'h0AAA, low_m)
        `TB_CHK("peak_m", 13'h1555, peak_m)
        i_host.write_word(`VICFG_OFS_SEL, 32'h12345677);
        rd_chk(`VICFG_OFS_SEL, 32'h00000077);
        `TB_CHK("peak_sel", 8'h77, peak_sel)
        stream(2'h1, 4'h5, 32'h0, 8'h77);
        `TB_CHK("q peak", 13'h1555, q_val)
        stream(2'h1, 4'h5, 32'h0, 8'h76);
        `TB_CHK("q low", 13'h0AAA, q_val)
        // unmapped place: write dropped, read gives zero
        i_host.write_word(16'h0040, 32'hFFFFFFFF);
        rd_chk(16'h0040, 32'h00000000);
        rd_chk(`VICFG_OFS_GEN, 32'h8001C35A);
        report_and_stop();
    end
endmodule
